// *** src/hw_integer_divider.sv ***
// 32-bit signed/unsigned iterative integer divider
`timescale 1ns/1ps
`default_nettype none
module hw_integer_divider (
  input wire logic mclk,
  input wire logic reset,
  input wire div_pkg::wr_req_t wr,
  input wire div_pkg::rd_req_t rd,
  output div_pkg::div_status_t status,
  output logic rd_valid,
  output logic [31:0] rd_data
);

  // ****************************************
  // state
  // ****************************************
  div_pkg::div_state_t state_q, state_d;
  logic [2:0] cnt_q, cnt_d;
  logic [31:0] dividend_q, dividend_d;
  logic [31:0] acc_q, acc_d;
  logic [31:0] quo_q, quo_d;
  logic [31:0] dsr_q, dsr_d;
  logic neg_q_q, neg_q_d;
  logic neg_r_q, neg_r_d;
  logic [31:0] quot_res_q, quot_res_d;
  logic [31:0] rem_res_q, rem_res_d;
  logic busy_q, busy_d;
  logic done_q, done_d;
  logic dz_q, dz_d;
  logic rd_valid_q, rd_valid_d;
  logic [31:0] rd_data_q, rd_data_d;

  logic start;
  logic [31:0] op_a;
  logic [31:0] op_b;
  logic [31:0] rem_c [0:div_pkg::BITS_PER_CYC];
  logic [31:0] quo_c [0:div_pkg::BITS_PER_CYC];

  function automatic logic [31:0] mag(input logic [31:0] v, input logic s);
    mag = (s && v[31]) ? 32'(-v) : v;
  endfunction : mag

  assign start = wr.divisor_we;
  assign op_a = dividend_q;
  assign op_b = wr.data;

  // ****************************************
  // datapath: four steps per cycle
  // ****************************************
  assign rem_c[0] = acc_q;
  assign quo_c[0] = quo_q;
  for (genvar i = 0; i < div_pkg::BITS_PER_CYC; i++) begin : g_step
    div_step u_step (
      .rem_i(rem_c[i]),
      .quo_i(quo_c[i]),
      .dsr_i(dsr_q),
      .rem_o(rem_c[i+1]),
      .quo_o(quo_c[i+1])
    );
  end

  // ****************************************
  // sequencing
  // ****************************************
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    dividend_d = dividend_q;
    acc_d = acc_q;
    quo_d = quo_q;
    dsr_d = dsr_q;
    neg_q_d = neg_q_q;
    neg_r_d = neg_r_q;
    quot_res_d = quot_res_q;
    rem_res_d = rem_res_q;
    busy_d = busy_q;
    done_d = done_q;
    dz_d = dz_q;
    if (wr.dividend_we && !start) begin
      dividend_d = wr.data;
    end
    if (start) begin
      state_d = div_pkg::ST_RUN;
      cnt_d = div_pkg::CNT_FIRST;
      busy_d = 1'b1;
      done_d = 1'b0;
      dz_d = (op_b == div_pkg::WORD_RESET);
      acc_d = div_pkg::WORD_RESET;
      quo_d = mag(op_a, wr.signed_mode);
      dsr_d = mag(op_b, wr.signed_mode);
      neg_q_d = wr.signed_mode && (op_a[31] ^ op_b[31]) && (|op_b);
      neg_r_d = wr.signed_mode && op_a[31];
    end else begin
      unique case (state_q)
        div_pkg::ST_IDLE: begin
        end
        div_pkg::ST_RUN: begin
          acc_d = rem_c[div_pkg::BITS_PER_CYC];
          quo_d = quo_c[div_pkg::BITS_PER_CYC];
          cnt_d = 3'(cnt_q + 3'h1);
          if (cnt_q == div_pkg::CNT_LAST) begin
            state_d = div_pkg::ST_IDLE;
            busy_d = 1'b0;
            done_d = 1'b1;
            quot_res_d = neg_q_q ? 32'(-quo_c[div_pkg::BITS_PER_CYC])
                                 : quo_c[div_pkg::BITS_PER_CYC];
            rem_res_d = neg_r_q ? 32'(-rem_c[div_pkg::BITS_PER_CYC])
                                : rem_c[div_pkg::BITS_PER_CYC];
          end
        end
        default: begin
          state_d = div_pkg::ST_IDLE;
          busy_d = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      state_q <= div_pkg::ST_IDLE;
      cnt_q <= div_pkg::CNT_FIRST;
      dividend_q <= div_pkg::WORD_RESET;
      acc_q <= div_pkg::WORD_RESET;
      quo_q <= div_pkg::WORD_RESET;
      dsr_q <= div_pkg::WORD_RESET;
      neg_q_q <= 1'b0;
      neg_r_q <= 1'b0;
      quot_res_q <= div_pkg::WORD_RESET;
      rem_res_q <= div_pkg::WORD_RESET;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      dz_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      dividend_q <= dividend_d;
      acc_q <= acc_d;
      quo_q <= quo_d;
      dsr_q <= dsr_d;
      neg_q_q <= neg_q_d;
      neg_r_q <= neg_r_d;
      quot_res_q <= quot_res_d;
      rem_res_q <= rem_res_d;
      busy_q <= busy_d;
      done_q <= done_d;
      dz_q <= dz_d;
    end
  end

  // ****************************************
  // result read port
  // ****************************************
  // a start in the same cycle also stalls, or stale data would escape
  always_comb begin
    rd_valid_d = 1'b0;
    rd_data_d = rd_data_q;
    if (rd.req && !rd_valid_q && !busy_q && !start) begin
      rd_valid_d = 1'b1;
      rd_data_d = (rd.sel == div_pkg::SEL_REM) ? rem_res_q : quot_res_q;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      rd_valid_q <= 1'b0;
      rd_data_q <= div_pkg::WORD_RESET;
    end else begin
      rd_valid_q <= rd_valid_d;
      rd_data_q <= rd_data_d;
    end
  end

  assign status = '{busy: busy_q, done: done_q, div_zero: dz_q};
  assign rd_valid = rd_valid_q;
  assign rd_data = rd_data_q;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  logic [31:0] chk_a_q, chk_b_q;
  logic chk_s_q;
  always_ff @(posedge mclk) begin
    if (reset) begin
      chk_a_q <= div_pkg::WORD_RESET;
      chk_b_q <= div_pkg::WORD_RESET;
      chk_s_q <= 1'b0;
    end else if (start) begin
      chk_a_q <= op_a;
      chk_b_q <= op_b;
      chk_s_q <= wr.signed_mode;
    end
  end

  start_clears_a: assert property (start |=> busy_q && !done_q)
    else $error("start did not clear done");
  restart_cnt_a: assert property (busy_q && start |=> cnt_q == 3'h0)
    else $error("restart did not reload count");
  run_busy_a: assert property (start ##1 !start [*7] |-> busy_q)
    else $error("busy dropped before eight cycles");
  latency_done_a: assert property (
      start ##1 !start [*8] |=> done_q && !busy_q)
    else $error("result not ready after eight cycles");
  zero_flag_a: assert property (
      start |=> dz_q == ($past(op_b) == 32'h0000_0000))
    else $error("zero divisor flag wrong");
  done_hold_a: assert property (
      done_q && !start |=> done_q && $stable(quot_res_q))
    else $error("completion flag lost");
  rd_stall_a: assert property (
      rd_valid_q |-> !$past(busy_q) && !$past(start))
    else $error("read answered during division");
  rd_data_a: assert property (
      rd.req && !rd_valid_q && !busy_q && !start && rd.sel == div_pkg::SEL_QUOT
      |=> rd_valid_q && rd_data_q == $past(quot_res_q))
    else $error("quotient read wrong");
  div_ident_a: assert property (
      $rose(done_q) && chk_b_q != 32'h0000_0000
      |-> chk_a_q == 32'(quot_res_q * chk_b_q + rem_res_q))
    else $error("quotient and remainder inconsistent");
  urem_range_a: assert property (
      $rose(done_q) && !chk_s_q && chk_b_q != 32'h0000_0000
      |-> rem_res_q < chk_b_q)
    else $error("unsigned remainder out of range");

  // done shows at the ninth edge after the start is taken
  signed_done_c: cover property (start && wr.signed_mode ##9 done_q);
  zero_div_c: cover property (start && wr.data == 32'h0000_0000 ##9 dz_q);
  restart_c: cover property (busy_q && start);
  read_stall_c: cover property (rd.req && busy_q ##[1:9] rd_valid_q);

endmodule : hw_integer_divider
`default_nettype wire

// *** common/div_pkg.sv ***
// shared constants and carrier types of the integer divider
// Contract
// - divides signed or unsigned, chosen by a software configuration input.
// - takes 32-bit dividend and 32-bit divisor, each written separately.
// - delivers 32-bit quotient and 32-bit remainder, each readable separately.
// - sets a readable flag when the divisor used is zero.
// - sets a completion flag once quotient and remainder are valid.
// - every division finishes within a fixed eight-cycle latency; a new divisor write during a division abandons the running one.
// - divisor write starts division; software loads dividend first, mode is taken with the divisor write.
// - quotient or remainder read during a division waits until ready.
package div_pkg;

  // ****************************************
  // sizes and counts
  // ****************************************
  localparam int unsigned DATA_W = 32;
  localparam int unsigned LATENCY_CYC = 8;
  localparam int unsigned BITS_PER_CYC = DATA_W / LATENCY_CYC;
  localparam int unsigned CNT_W = 3;
  localparam logic [2:0] CNT_FIRST = 3'h0;
  localparam logic [2:0] CNT_LAST = 3'(LATENCY_CYC - 1);
  localparam logic [31:0] WORD_RESET = 32'h0000_0000;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN = 2'b01
  } div_state_t;

  typedef enum logic {
    SEL_QUOT = 1'b0,
    SEL_REM = 1'b1
  } rd_sel_t;

  typedef struct packed {
    logic dividend_we;
    logic divisor_we;
    logic signed_mode;
    logic [31:0] data;
  } wr_req_t;

  typedef struct packed {
    logic req;
    rd_sel_t sel;
  } rd_req_t;

  typedef struct packed {
    logic busy;
    logic done;
    logic div_zero;
  } div_status_t;

endpackage : div_pkg

// *** src/div_step.sv ***
// one restoring division step on magnitudes
`timescale 1ns/1ps
`default_nettype none
module div_step (
  input wire logic [31:0] rem_i,
  input wire logic [31:0] quo_i,
  input wire logic [31:0] dsr_i,
  output logic [31:0] rem_o,
  output logic [31:0] quo_o
);

  logic [32:0] part;
  logic [32:0] diff;
  logic take;

  always_comb begin
    part = {rem_i, quo_i[31]};
    diff = part - {1'b0, dsr_i};
    take = ~diff[32];
    rem_o = take ? diff[31:0] : part[31:0];
    quo_o = {quo_i[30:0], take};
  end

endmodule : div_step
`default_nettype wire

// *** verification/core_model.sv ***
// core-side model issuing held read requests
`timescale 1ns/1ps
`default_nettype none
module core_model (
  input wire logic mclk,
  input wire logic rd_valid,
  output div_pkg::rd_req_t rd
);
  initial rd = '{1'b0, div_pkg::SEL_QUOT};
  task automatic read(input div_pkg::rd_sel_t sel, output bit ok);
    ok = 1'b0;
    @(posedge mclk);
    rd <= '{1'b1, sel};
    for (int i = 0; i < 40 && !ok; i++) begin
      @(posedge mclk);
      ok = (rd_valid === 1'b1);
    end
    rd <= '{1'b0, div_pkg::SEL_QUOT};
  endtask : read
endmodule : core_model
`default_nettype wire

// *** verification/testbench.sv ***
// self-checking bench of the integer divider
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  div_pkg::wr_req_t wr = '0;
  div_pkg::rd_req_t rd;
  div_pkg::div_status_t status;
  logic rd_valid;
  logic [31:0] rd_data;
  logic [31:0] exp_q[$];
  logic [31:0] seed = 32'h2E4F2D63;
  int fail_count = 0;
  int tests_run = 0;
  always #5 mclk = ~mclk;
  hw_integer_divider u_dut (.mclk(mclk), .reset(reset), .wr(wr), .rd(rd),
    .status(status), .rd_valid(rd_valid), .rd_data(rd_data));
  core_model u_core (.mclk(mclk), .rd_valid(rd_valid), .rd(rd));
  // ****
  // helpers
  // ****
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  // zero divisor handled first, in signed and unsigned mode alike
  function automatic void exp_div(input logic [31:0] a, input logic [31:0] b,
    input logic s, output logic [31:0] q, output logic [31:0] r);
    if (b == 32'h0) begin
      q = 32'hFFFF_FFFF;
      r = a;
    end else if (s && a == 32'h8000_0000 && b == 32'hFFFF_FFFF) begin
      q = 32'h8000_0000;
      r = 32'h0;
    end else if (s) begin
      q = $signed(a) / $signed(b);
      r = $signed(a) % $signed(b);
    end else begin
      q = a / b;
      r = a % b;
    end
  endfunction : exp_div
  task automatic cmp_word(input logic [31:0] got, input logic [31:0] e);
    tests_run++;
    if (got !== e) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, e);
    end
  endtask : cmp_word
  task automatic cmp_flags(input div_pkg::div_status_t got,
    input div_pkg::div_status_t e);
    cmp_word({29'h0, got}, {29'h0, e});
  endtask : cmp_flags
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : conclude
  task automatic hang();
    fail_count++;
    conclude();
  endtask : hang
  always @(posedge mclk) begin
    if (rd_valid === 1'b1) begin
      if (exp_q.size() > 0) cmp_word(rd_data, exp_q.pop_front());
      else hang();
    end
  end
  task automatic start(input logic [31:0] a, input logic [31:0] b,
    input logic s);
    @(posedge mclk);
    wr <= '{1'b1, 1'b0, s, a};
    @(posedge mclk);
    wr <= '{1'b0, 1'b1, s, b};
    @(posedge mclk);
    wr <= '0;
    #1;
    cmp_flags(status, '{1'b1, 1'b0, b == 32'h0});
  endtask : start
  task automatic finish_op();
    int n;
    n = 0;
    while (status.done !== 1'b1 && n < 20) begin
      @(posedge mclk);
      #1;
      n++;
    end
    if (n == 20) hang();
    cmp_word(32'(n), 32'h8);
  endtask : finish_op
  task automatic rd_check(input div_pkg::rd_sel_t sel, input logic [31:0] e);
    bit ok;
    exp_q.push_back(e);
    u_core.read(sel, ok);
    if (!ok) hang();
  endtask : rd_check
  task automatic op(input logic [31:0] a, input logic [31:0] b,
    input logic s);
    logic [31:0] q, r;
    exp_div(a, b, s, q, r);
    start(a, b, s);
    finish_op();
    rd_check(div_pkg::SEL_QUOT, q);
    rd_check(div_pkg::SEL_REM, r);
  endtask : op
  // ****
  // main sequence
  // ****
  initial begin
    logic [31:0] a, b, q, r;
    repeat (20) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    #1;
    cmp_flags(status, '0); // RESET
    rd_check(div_pkg::SEL_REM, 32'h0);
    for (int i = 0; i < 24; i++) begin
      a = rnd();
      b = rnd();
      b = (b >> b[4:0]) | 32'h1;
      op(a, b, i[0]);
    end
    op(32'h8000_0000, 32'hFFFF_FFFF, 1'b1);
    op(32'h1234_5678, 32'h0, 1'b0);
    op(32'hFFFF_FFF9, 32'h2, 1'b1);
    exp_div(32'h0000_0064, 32'h7, 1'b0, q, r);
    start(32'h0000_0064, 32'h7, 1'b0);
    rd_check(div_pkg::SEL_QUOT, q);
    cmp_flags(status, '{1'b0, 1'b1, 1'b0});
    exp_div(32'h0000_03E8, 32'h3, 1'b1, q, r);
    start(32'hFFFF_0000, 32'h5, 1'b0);
    repeat (3) @(posedge mclk);
    start(32'h0000_03E8, 32'h3, 1'b1);
    finish_op();
    rd_check(div_pkg::SEL_REM, r);
    // mid-run reset drops the running division and old results
    start(32'h0000_0064, 32'h7, 1'b0);
    @(posedge mclk);
    reset <= 1'b1;
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    #1;
    cmp_flags(status, '0);
    rd_check(div_pkg::SEL_QUOT, 32'h0);
    repeat (3) @(posedge mclk);
    cmp_word(32'(exp_q.size()), 32'h0);
    conclude();
  end
endmodule : testbench
`default_nettype wire
